// [crm_pkg.sv]
// constants shared by the clock and reset manager
package crm_pkg;
	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] CRM_IDX_CLOCK_MODE_CONTROL = 8'h5b;
	localparam logic [7:0] CRM_IDX_LOW_SPEED_CLOCK_GATES = 8'h5c;
	localparam logic [7:0] CRM_IDX_HIGH_SPEED_CLOCK_GATES = 8'h5d;
	localparam logic [7:0] CRM_RESET_VALUE = 8'h00;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CRM_BIT_DIVIDER = 0;
	localparam int CRM_BIT_RUN_MODE = 1;
	localparam int CRM_BIT_LOCK = 2;
	localparam int CRM_BIT_REG_OFF = 7;
	localparam int CRM_BIT_DEBUG = 0;
	localparam int CRM_BIT_TIMER = 1;
	localparam int CRM_BIT_WATCHDOG = 2;
	localparam int CRM_BIT_SPI = 3;
	localparam int CRM_BIT_TIMEBASE = 4;
	localparam int CRM_BIT_STORAGE = 0;
	localparam int CRM_BIT_ENCODER = 1;
	localparam int CRM_BIT_DECODER = 2;
	localparam int CRM_BIT_USB = 3;
	// writable masks, reserved bits read as zero
	localparam logic [7:0] CRM_MODE_WMASK = 8'h83;
	localparam logic [7:0] CRM_LOW_WMASK = 8'h1e;
	localparam logic [7:0] CRM_HIGH_WMASK = 8'h0f;
	// ------------------------------------------------------------
	// reset sequence counts
	// ------------------------------------------------------------
	localparam logic [9:0] CRM_DELAY_CPU_CYCLES = 10'h200;
	localparam logic [1:0] CRM_FETCH_CYCLES = 2'h2;
	localparam logic [7:0] CRM_INTERNAL_ACTIVE_CYCLES = 8'h10;
	localparam logic [15:0] CRM_RESET_VECTOR_LOW = 16'hfffe;
	localparam logic [15:0] CRM_RESET_VECTOR_HIGH = 16'hffff;
	// cpu clock divide counts, terminal values
	localparam logic [1:0] CRM_DIV2_LAST = 2'h1;
	localparam logic [1:0] CRM_DIV4_LAST = 2'h3;

	typedef enum logic [3:0] {
		CRM_ST_ACTIVE = 4'b0001,
		CRM_ST_DELAY = 4'b0010,
		CRM_ST_FETCH = 4'b0100,
		CRM_ST_RUN = 4'b1000
	} crm_state_t;
endpackage

// [crm_clock_reset_manager.sv]
// clock selection, peripheral clock gating and reset sequencing
// Operation
// - low power mode: oscillator clocks, pll off, no usb clock
// - full power with lock: pll clocks, cpu half or quarter
// - reset starts in low power; run-mode bit requests full power
// - regulator-off bit lowers regulator current during halt
// - regulator-off bit clears itself on wake from halt
// - lock bit reads live pll lock status, read only
// - divider bit selects cpu clock source over two or four
// - full power requested without lock stays on oscillator clocks
// - low speed gates hold timebase clock enable
// - low speed gates hold spi, watchdog and timer enables
// - hardware watchdog option forces watchdog clock on
// - debug clock enable can be set, cleared only by reset
// - high speed gates hold usb, decoder, encoder, storage enables
// - reset sources: pin, watchdog underflow, illegal opcode
// - reset vector fetched from fffe and ffff
// - 512 cpu cycles pass before the vector fetch
// - vector fetch lasts two clock cycles
// - reset pin acts asynchronously, even with clocks stopped
// - watchdog underflow holds reset a minimum time, then sequence
// - code neither opcode nor prebyte causes reset
// - valid prebyte with valid opcode never causes reset
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module crm_clock_reset_manager
	import crm_pkg::*;
#(
	parameter int ADDR_WIDTH = 10
) (
	// system
	input wire logic clk,
	input wire logic reset_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// pll and power
	input wire logic pll_locked,
	input wire logic halt_entry,
	input wire logic halt_wakeup,
	output logic pll_enable,
	output logic clock_from_pll,
	output logic cpu_clock_tick,
	output logic regulator_low_power,
	// peripheral clock enables
	output logic timebase_clock_enable,
	output logic spi_clock_enable,
	output logic watchdog_clock_enable,
	output logic timer_clock_enable,
	output logic debug_clock_enable,
	output logic usb_clock_enable,
	output logic rs_decoder_clock_enable,
	output logic rs_encoder_clock_enable,
	output logic storage_controller_clock_enable,
	// reset sources
	input wire logic hardware_watchdog_option,
	input wire logic watchdog_underflow,
	input wire logic opcode_strobe,
	input wire logic opcode_defined,
	input wire logic opcode_is_prebyte,
	// reset sequencer outputs
	output logic core_reset_n,
	output logic vector_fetch,
	output logic [15:0] vector_address
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_WIDTH-1:0] adr,
			input logic [7:0] idx);
		hit = (adr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(idx)) &&
			(adr[1:0] == 2'h0);
	endfunction

	crm_state_t state;
	logic [7:0] mode_reg;
	logic [7:0] low_reg;
	logic [7:0] high_reg;
	logic in_halt;
	logic use_pll;
	logic [1:0] div_cnt;
	logic [9:0] seq_cnt;
	logic [7:0] active_cnt;
	logic [1:0] fetch_cnt;
	logic illegal_opcode;
	logic internal_reset;
	logic sync_clear;
	logic wr_en;
	logic rd_en;
	logic div_last;
	logic cpu_tick;
	logic [7:0] mode_view;

	// ------------------------------------------------------------
	// bus strobes
	// ------------------------------------------------------------
	// one wait state: ack a cycle after the request, then drop it
	// a write lands on the edge where the master samples ack high
	assign wr_en = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
		wb_sel_i[0];
	assign rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

	// ------------------------------------------------------------
	// internal reset sources
	// ------------------------------------------------------------
	// a pair prebyte plus defined opcode is never flagged here
	assign illegal_opcode = opcode_strobe && !opcode_defined &&
		!opcode_is_prebyte;
	assign internal_reset = watchdog_underflow || illegal_opcode;
	// registers return to reset values during any active phase
	assign sync_clear = (state == CRM_ST_ACTIVE);

	// ------------------------------------------------------------
	// cpu clock divider
	// ------------------------------------------------------------
	assign div_last = (div_cnt == (mode_reg[CRM_BIT_DIVIDER] ?
		CRM_DIV4_LAST : CRM_DIV2_LAST));
	assign cpu_tick = div_last;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 2'h0;
		end else if (div_last || sync_clear) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_clock_tick <= 1'b0;
		end else begin
			cpu_clock_tick <= cpu_tick;
		end
	end

	// ------------------------------------------------------------
	// clock mode register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg <= CRM_RESET_VALUE;
		end else if (sync_clear) begin
			mode_reg <= CRM_RESET_VALUE;
		end else begin
			if (wr_en && hit(wb_adr_i, CRM_IDX_CLOCK_MODE_CONTROL)) begin
				mode_reg <= wb_dat_i[7:0] & CRM_MODE_WMASK;
			end
			// cpu is stopped while halted, so the wake clear cannot race
			if (halt_wakeup && in_halt) begin
				mode_reg[CRM_BIT_REG_OFF] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// halt and regulator control
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_halt <= 1'b0;
		end else if (sync_clear || halt_wakeup) begin
			in_halt <= 1'b0;
		end else if (halt_entry) begin
			in_halt <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regulator_low_power <= 1'b0;
		end else begin
			// relies on software having set the bit before halt
			regulator_low_power <= in_halt && !halt_wakeup &&
				mode_reg[CRM_BIT_REG_OFF];
		end
	end

	// ------------------------------------------------------------
	// clock source selection
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pll_enable <= 1'b0;
		end else begin
			pll_enable <= mode_reg[CRM_BIT_RUN_MODE];
		end
	end

	// following pll lock only at a divider wrap keeps cpu pulses whole; run mode off switches at once
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			use_pll <= 1'b0;
		end else if (sync_clear || !mode_reg[CRM_BIT_RUN_MODE]) begin
			use_pll <= 1'b0;
		end else if (div_last) begin
			use_pll <= pll_locked;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clock_from_pll <= 1'b0;
		end else begin
			clock_from_pll <= use_pll;
		end
	end

	// ------------------------------------------------------------
	// peripheral clock gate registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_reg <= CRM_RESET_VALUE;
		end else if (sync_clear) begin
			low_reg <= CRM_RESET_VALUE;
		end else if (wr_en &&
				hit(wb_adr_i, CRM_IDX_LOW_SPEED_CLOCK_GATES)) begin
			low_reg <= wb_dat_i[7:0] & CRM_LOW_WMASK;
			if (wb_dat_i[CRM_BIT_DEBUG] || low_reg[CRM_BIT_DEBUG]) begin
				low_reg[CRM_BIT_DEBUG] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			high_reg <= CRM_RESET_VALUE;
		end else if (sync_clear) begin
			high_reg <= CRM_RESET_VALUE;
		end else if (wr_en &&
				hit(wb_adr_i, CRM_IDX_HIGH_SPEED_CLOCK_GATES)) begin
			high_reg <= wb_dat_i[7:0] & CRM_HIGH_WMASK;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timebase_clock_enable <= 1'b0;
			spi_clock_enable <= 1'b0;
			watchdog_clock_enable <= 1'b0;
			timer_clock_enable <= 1'b0;
			debug_clock_enable <= 1'b0;
		end else begin
			timebase_clock_enable <= low_reg[CRM_BIT_TIMEBASE];
			spi_clock_enable <= low_reg[CRM_BIT_SPI];
			watchdog_clock_enable <= low_reg[CRM_BIT_WATCHDOG] ||
				hardware_watchdog_option;
			timer_clock_enable <= low_reg[CRM_BIT_TIMER];
			debug_clock_enable <= low_reg[CRM_BIT_DEBUG];
		end
	end

	// usb has no clock until the pll is actually the source
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			usb_clock_enable <= 1'b0;
			rs_decoder_clock_enable <= 1'b0;
			rs_encoder_clock_enable <= 1'b0;
			storage_controller_clock_enable <= 1'b0;
		end else begin
			usb_clock_enable <= high_reg[CRM_BIT_USB] &&
				use_pll;
			rs_decoder_clock_enable <= high_reg[CRM_BIT_DECODER];
			rs_encoder_clock_enable <= high_reg[CRM_BIT_ENCODER];
			storage_controller_clock_enable <=
				high_reg[CRM_BIT_STORAGE];
		end
	end

	// ------------------------------------------------------------
	// bus read and acknowledge
	// ------------------------------------------------------------
	always_comb begin
		mode_view = mode_reg;
		mode_view[CRM_BIT_LOCK] = pll_locked;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// unmapped addresses are acknowledged and read as zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_dat_o <= 32'h0;
		end else if (rd_en) begin
			if (hit(wb_adr_i, CRM_IDX_CLOCK_MODE_CONTROL)) begin
				wb_dat_o <= {24'h0, mode_view};
			end else if (hit(wb_adr_i, CRM_IDX_LOW_SPEED_CLOCK_GATES)) begin
				wb_dat_o <= {24'h0, low_reg};
			end else if (hit(wb_adr_i,
					CRM_IDX_HIGH_SPEED_CLOCK_GATES)) begin
				wb_dat_o <= {24'h0, high_reg};
			end else begin
				wb_dat_o <= 32'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// reset sequencer
	// ------------------------------------------------------------
	// the pin is the asynchronous reset itself, so it works in halt
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= CRM_ST_DELAY;
			seq_cnt <= 10'h0;
			active_cnt <= 8'h0;
			fetch_cnt <= 2'h0;
		end else if (internal_reset) begin
			state <= CRM_ST_ACTIVE;
			active_cnt <= 8'h0;
		end else begin
			case (state)
				CRM_ST_ACTIVE: begin
					if (active_cnt == CRM_INTERNAL_ACTIVE_CYCLES - 8'h1) begin
						state <= CRM_ST_DELAY;
						seq_cnt <= 10'h0;
					end else begin
						active_cnt <= active_cnt + 8'h1;
					end
				end
				CRM_ST_DELAY: begin
					if (cpu_tick) begin
						if (seq_cnt == CRM_DELAY_CPU_CYCLES - 10'h1) begin
							state <= CRM_ST_FETCH;
							fetch_cnt <= 2'h0;
						end else begin
							seq_cnt <= seq_cnt + 10'h1;
						end
					end
				end
				CRM_ST_FETCH: begin
					if (fetch_cnt == CRM_FETCH_CYCLES - 2'h1) begin
						state <= CRM_ST_RUN;
					end else begin
						fetch_cnt <= fetch_cnt + 2'h1;
					end
				end
				CRM_ST_RUN: begin
					state <= CRM_ST_RUN;
				end
				default: begin
					state <= CRM_ST_ACTIVE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			vector_fetch <= 1'b0;
			vector_address <= 16'h0;
			core_reset_n <= 1'b0;
		end else begin
			vector_fetch <= (state == CRM_ST_FETCH) && !internal_reset;
			vector_address <= (fetch_cnt == 2'h0) ? CRM_RESET_VECTOR_LOW :
				CRM_RESET_VECTOR_HIGH;
			core_reset_n <= (state == CRM_ST_RUN) && !internal_reset;
		end
	end

endmodule
`default_nettype wire

// [crm_reset_source.sv]
// model of the external reset circuitry on the reset pin
`timescale 1ns/10ps
`default_nettype none
module crm_reset_source (
	// system
	input wire logic clk,
	// request from the bench
	input wire logic reset_request,
	// reset pin, weak pull-up keeps it high when idle
	output logic reset_n
);
	// ----------------------------------------------------------
	// power-on pulse, then pulses on request
	// ----------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		forever begin
			@(posedge clk);
			if (reset_request) begin
				// pulse well above the minimum width
				reset_n <= 1'b0;
				repeat (8) @(posedge clk);
				reset_n <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [crm_checker_assertions.sv]
// concurrent checks on the clock and reset manager ports
`timescale 1ns/10ps
`default_nettype none
module crm_checker (
	// system
	input wire logic clk,
	input wire logic reset_n,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// clocks and power
	input wire logic halt_wakeup,
	input wire logic halt_entry,
	input wire logic pll_locked,
	input wire logic clock_from_pll,
	input wire logic usb_clock_enable,
	input wire logic regulator_low_power,
	input wire logic watchdog_clock_enable,
	input wire logic debug_clock_enable,
	input wire logic hardware_watchdog_option,
	// reset
	input wire logic watchdog_underflow,
	input wire logic opcode_strobe,
	input wire logic opcode_defined,
	input wire logic opcode_is_prebyte,
	input wire logic core_reset_n,
	input wire logic vector_fetch,
	input wire logic [15:0] vector_address
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------------------------
	// properties
	// ----------------------------------------------------------
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");
	// usb and the pll source are both registered from use_pll on the same edge, so neither lags
	property p_usb_off;
		!clock_from_pll && !$past(clock_from_pll) && !$past(clock_from_pll, 2)
			|-> !usb_clock_enable;
	endproperty
	a_usb_off: assert property (p_usb_off) else $error("usb clock without pll");
	property p_pll_src;
		$rose(clock_from_pll) |-> $past(pll_locked);
	endproperty
	a_pll_src: assert property (p_pll_src) else $error("pll taken unlocked");
	property p_vector;
		$rose(vector_fetch) |-> vector_address == 16'hfffe
			##1 vector_fetch && vector_address == 16'hffff ##1 !vector_fetch;
	endproperty
	a_vector: assert property (p_vector) else $error("vector fetch wrong");
	property p_release;
		$rose(core_reset_n) |-> !vector_fetch
			&& ($past(vector_fetch) || $past(vector_fetch, 2));
	endproperty
	a_release: assert property (p_release) else $error("release without fetch");
	property p_active_min;
		$fell(core_reset_n) |-> !core_reset_n [*8];
	endproperty
	a_active_min: assert property (p_active_min) else $error("reset too short");
	property p_wd_reset;
		watchdog_underflow |-> ##[1:3] !core_reset_n;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("no watchdog reset");
	property p_illegal;
		opcode_strobe && !opcode_defined && !opcode_is_prebyte
			|-> ##[1:3] !core_reset_n;
	endproperty
	a_illegal: assert property (p_illegal) else $error("no opcode reset");
	property p_legal;
		opcode_strobe && (opcode_defined || opcode_is_prebyte) && core_reset_n
			&& !watchdog_underflow |=> core_reset_n;
	endproperty
	a_legal: assert property (p_legal) else $error("spurious opcode reset");
	property p_hw_wd;
		hardware_watchdog_option && $past(hardware_watchdog_option)
			|-> watchdog_clock_enable;
	endproperty
	a_hw_wd: assert property (p_hw_wd) else $error("watchdog clock off");
	property p_debug;
		$fell(debug_clock_enable) |-> ##[0:2] !core_reset_n;
	endproperty
	a_debug: assert property (p_debug) else $error("debug clock cleared");
	property p_reg_on;
		$rose(regulator_low_power) |-> $past(halt_entry) || $past(halt_entry, 2);
	endproperty
	a_reg_on: assert property (p_reg_on) else $error("regulator low outside halt");
	property p_reg_wake;
		halt_wakeup && regulator_low_power |-> ##[1:2] !regulator_low_power;
	endproperty
	a_reg_wake: assert property (p_reg_wake) else $error("regulator stays low");
	// ----------------------------------------------------------
	// coverage
	// ----------------------------------------------------------
	c_pll: cover property ($rose(clock_from_pll));
	c_fetch: cover property ($rose(vector_fetch));
	c_wake: cover property ($fell(regulator_low_power));
endmodule
`default_nettype wire

// [crm_clock_reset_manager_bench.sv]
// self-checking bench for the clock and reset manager
`timescale 1ns/10ps
`default_nettype none
`define check(n, e, g) begin n_tests++; \
	if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module crm_clock_reset_manager_bench;
	import crm_pkg::*;
	logic clk = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic pll_locked = 1'b0, halt_entry = 1'b0, halt_wakeup = 1'b0;
	logic hardware_watchdog_option = 1'b0, watchdog_underflow = 1'b0;
	logic opcode_strobe = 1'b0, opcode_defined = 1'b0, opcode_is_prebyte = 1'b0;
	logic reset_request = 1'b0, reset_n, wb_ack_o, pll_enable, clock_from_pll;
	logic cpu_clock_tick, regulator_low_power, timebase_clock_enable;
	logic spi_clock_enable, watchdog_clock_enable, timer_clock_enable;
	logic debug_clock_enable, usb_clock_enable, rs_decoder_clock_enable;
	logic rs_encoder_clock_enable, storage_controller_clock_enable;
	logic core_reset_n, vector_fetch;
	logic [15:0] vector_address;
	logic [7:0] q;
	logic [4:0] v;
	logic [3:0] wb_sel_i = 4'h1;
	int err_count = 0, n_tests = 0, i, g;
	localparam logic [9:0] A_MODE = 10'h16c, A_LOW = 10'h170, A_HIGH = 10'h174;
	always #12.5 clk = ~clk;
	crm_reset_source i_crm_reset_source (.clk(clk),
		.reset_request(reset_request), .reset_n(reset_n));
	crm_clock_reset_manager i_crm_clock_reset_manager (.clk(clk),
		.reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pll_locked(pll_locked), .halt_entry(halt_entry),
		.halt_wakeup(halt_wakeup), .pll_enable(pll_enable),
		.clock_from_pll(clock_from_pll), .cpu_clock_tick(cpu_clock_tick),
		.regulator_low_power(regulator_low_power),
		.timebase_clock_enable(timebase_clock_enable),
		.spi_clock_enable(spi_clock_enable),
		.watchdog_clock_enable(watchdog_clock_enable),
		.timer_clock_enable(timer_clock_enable),
		.debug_clock_enable(debug_clock_enable),
		.usb_clock_enable(usb_clock_enable),
		.rs_decoder_clock_enable(rs_decoder_clock_enable),
		.rs_encoder_clock_enable(rs_encoder_clock_enable),
		.storage_controller_clock_enable(storage_controller_clock_enable),
		.hardware_watchdog_option(hardware_watchdog_option),
		.watchdog_underflow(watchdog_underflow), .opcode_strobe(opcode_strobe),
		.opcode_defined(opcode_defined), .opcode_is_prebyte(opcode_is_prebyte),
		.core_reset_n(core_reset_n), .vector_fetch(vector_fetch),
		.vector_address(vector_address));
	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int k;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		k = 0;
		do begin @(posedge clk); k++; end while (wb_ack_o !== 1'b1 && k < 40);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k >= 40) begin err_count++; results(); end
	endtask
	task automatic rd(input string n, input logic [9:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		`check(n, e, q)
	endtask
	// reset may take a moment to start, so wait for high only
	task automatic wait_core;
		i = 0;
		while (core_reset_n !== 1'b1 && i < 3000) begin @(posedge clk); i++; end
		if (i >= 3000) begin err_count++; results(); end
	endtask
	task automatic gap;
		do begin @(posedge clk); g++; end while (cpu_clock_tick !== 1'b1 && g < 99);
		g = 0;
		do begin @(posedge clk); g++; end while (cpu_clock_tick !== 1'b1 && g < 20);
	endtask
	task automatic op(input logic d, input logic p);
		@(posedge clk);
		opcode_strobe <= 1'b1;
		opcode_defined <= d;
		opcode_is_prebyte <= p;
		@(posedge clk);
		opcode_strobe <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// ----------------------------------------------------------
	// sequence
	// ----------------------------------------------------------
	initial begin
		i = 0;
		while (reset_n !== 1'b1 && i < 40) begin @(posedge clk); i++; end
		i = 0;
		while (vector_fetch !== 1'b1 && i < 3000) begin @(posedge clk); i++; end
		if (i >= 3000) begin err_count++; results(); end
		`check("delay", 1'b1, i >= 1024 && i <= 1030)
		`check("vec lo", 16'hfffe, vector_address)
		@(posedge clk);
		`check("vec hi", 17'h1ffff, {vector_fetch, vector_address})
		wait_core();
		rd("mode", A_MODE, 8'h00);
		rd("low", A_LOW, 8'h00);
		rd("high", A_HIGH, 8'h00);
		rd("unmapped", 10'h000, 8'h00);
		$display("test reset done");
		wb(1'b1, A_MODE, 8'h02);
		repeat (8) @(posedge clk);
		`check("unlocked", 2'b10, {pll_enable, clock_from_pll})
		gap();
		`check("gap", 2, g)
		rd("mode", A_MODE, 8'h02);
		pll_locked <= 1'b1;
		repeat (8) @(posedge clk);
		`check("pll src", 1'b1, clock_from_pll)
		rd("mode", A_MODE, 8'h06);
		wb(1'b1, A_HIGH, 8'hff);
		rd("high", A_HIGH, 8'h0f);
		v = {1'b0, usb_clock_enable, rs_decoder_clock_enable,
			rs_encoder_clock_enable, storage_controller_clock_enable};
		`check("hs", 5'h0f, v)
		// a write without the low byte lane must leave the register alone
		wb_sel_i <= 4'h0;
		wb(1'b1, A_HIGH, 8'h00);
		wb_sel_i <= 4'h1;
		rd("no lane", A_HIGH, 8'h0f);
		wb(1'b1, A_MODE, 8'h03);
		gap();
		`check("gap", 4, g)
		wb(1'b1, A_MODE, 8'h00);
		repeat (8) @(posedge clk);
		`check("lp", 3'b000, {pll_enable, clock_from_pll, usb_clock_enable})
		gap();
		`check("gap", 2, g)
		$display("test clock modes done");
		wb(1'b1, A_LOW, 8'hff);
		rd("low", A_LOW, 8'h1f);
		v = {timebase_clock_enable, spi_clock_enable, watchdog_clock_enable,
			timer_clock_enable, debug_clock_enable};
		`check("ls", 5'h1f, v)
		wb(1'b1, A_LOW, 8'h00);
		rd("low", A_LOW, 8'h01);
		hardware_watchdog_option <= 1'b1;
		repeat (3) @(posedge clk);
		`check("hw wd", 2'b11, {watchdog_clock_enable, debug_clock_enable})
		hardware_watchdog_option <= 1'b0;
		// software arms the regulator before halting
		wb(1'b1, A_MODE, 8'h80);
		halt_entry <= 1'b1;
		@(posedge clk);
		halt_entry <= 1'b0;
		repeat (3) @(posedge clk);
		`check("reg low", 1'b1, regulator_low_power)
		halt_wakeup <= 1'b1;
		@(posedge clk);
		halt_wakeup <= 1'b0;
		repeat (3) @(posedge clk);
		`check("reg on", 1'b0, regulator_low_power)
		// the pll is still locked, so the live lock bit reads one
		rd("mode", A_MODE, 8'h04);
		$display("test gates and halt done");
		op(1'b1, 1'b0);
		op(1'b1, 1'b1);
		`check("legal", 1'b1, core_reset_n)
		op(1'b0, 1'b0);
		`check("illegal", 1'b0, core_reset_n)
		wait_core();
		rd("low", A_LOW, 8'h00);
		wb(1'b1, A_LOW, 8'h01);
		watchdog_underflow <= 1'b1;
		@(posedge clk);
		watchdog_underflow <= 1'b0;
		repeat (3) @(posedge clk);
		`check("wd rst", 1'b0, core_reset_n)
		wait_core();
		rd("low", A_LOW, 8'h00);
		reset_request <= 1'b1;
		@(posedge clk);
		reset_request <= 1'b0;
		repeat (3) @(posedge clk);
		`check("pin rst", 1'b0, core_reset_n)
		wait_core();
		$display("test resets done");
		results();
	end
endmodule
bind crm_clock_reset_manager crm_checker i_crm_checker (.clk(clk),
	.reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .halt_wakeup(halt_wakeup), .halt_entry(halt_entry),
	.pll_locked(pll_locked), .clock_from_pll(clock_from_pll),
	.usb_clock_enable(usb_clock_enable),
	.regulator_low_power(regulator_low_power),
	.watchdog_clock_enable(watchdog_clock_enable),
	.debug_clock_enable(debug_clock_enable),
	.hardware_watchdog_option(hardware_watchdog_option),
	.watchdog_underflow(watchdog_underflow), .opcode_strobe(opcode_strobe),
	.opcode_defined(opcode_defined), .opcode_is_prebyte(opcode_is_prebyte),
	.core_reset_n(core_reset_n), .vector_fetch(vector_fetch),
	.vector_address(vector_address));
`default_nettype wire
